/* cer_pkg.sv */
// constants and types for the configurable embedded ram block
// assumes one system clock; user logic on the same clock drives the data ports
package cer_pkg;

  // ***************************************************
  // storage geometry
  // ***************************************************
  localparam int unsigned MEM_BITS   = 4096;
  localparam int unsigned PHYS_WIDTH = 16;
  localparam int unsigned PHYS_DEPTH = MEM_BITS / PHYS_WIDTH;
  localparam int unsigned PHYS_AW    = 8;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned LEVEL_W    = 12;

  // ***************************************************
  // register map, byte offsets on the 4-bit address port
  // ***************************************************
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_LOAD_ADDR = 4'h4;
  localparam logic [3:0] OFS_LOAD_DATA = 4'h8;
  localparam logic [3:0] OFS_STATUS    = 4'hC;

  // ***************************************************
  // control and status register fields
  // ***************************************************
  localparam int unsigned CTRL_W       = 11;
  localparam int unsigned STAT_EMPTY   = 0;
  localparam int unsigned STAT_FULL    = 1;
  localparam int unsigned STAT_LEVEL   = 2;
  localparam logic [10:0] CTRL_RESET   = 11'h7E2;
  localparam logic [1:0]  RATIO_RESET  = 2'h0;

  typedef enum logic [1:0] {
    CER_MODE_SP_RAM = 2'h0,
    CER_MODE_ROM    = 2'h1,
    CER_MODE_DP_RAM = 2'h2,
    CER_MODE_FIFO   = 2'h3
  } cer_mode_e;

  // ratio 0..3 : 256x16, 512x8, 1024x4, 2048x2
  typedef struct packed {
    logic      reg_q;
    logic      reg_re;
    logic      reg_raddr;
    logic      reg_we;
    logic      reg_waddr;
    logic      reg_wdata;
    logic      split_io;
    logic [1:0] ratio;
    cer_mode_e mode;
  } cer_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic [PHYS_WIDTH-1:0] data;
    logic                  en;
  } cer_wr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              en;
  } cer_rd_s;

endpackage

/* cer_mem.sv */
// 256 x 16 storage array with per-bit write mask and registered read data
// assumes the caller has already mapped the aspect ratio onto word and lane
`timescale 1ns/1ps
module cer_mem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned AW    = 8
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wmask_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_reg [0:(1<<AW)-1];

  // contents are not touched by clear: only writes on we_i, from configuration load or the user port, rewrite them
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= (mem_reg[waddr_i] & ~wmask_i) | (wdata_i & wmask_i);
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_reg[raddr_i];
  end

endmodule

/* cer_block.sv */
// configurable 4096-bit embedded ram block: ram, rom, dual-port ram or fifo
// assumes write and read clocks arrive as pins sampled on clk_i, and that
// address, data and enables come from fabric logic clocked by clk_i
//
// Notes on behaviour
// - storage is exactly 4096 bits, used as ram, rom, dual-port or fifo.
// - mode field selects ram, read-only, dual-port ram or fifo storage.
// - aspect ratio is 256x16, 512x8, 1024x4 or 2048x2.
// - rom contents load once at configuration, then user port only reads.
// - in dual-port mode write and read sections use their own clocks.
// - each section has its own clock enable, except in single-port mode where reads use the write one; disabled sections ignore edges.
// - optional arrangement: input registers on one clock, output on the other.
// - clear input asynchronously clears the section, fifo and read output registers; configuration registers keep their values.
// - write strobe is made internally, timed from the write clock edge.
// - registering chosen per path; unchosen paths pass straight through.
// - single-port mode: one address and one clock for read and write.
// - deeper or wider memories are built by joining blocks outside.
`timescale 1ns/1ps
module cer_block #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned AW     = 11
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              clear_i,
  input  wire logic              wr_clk_i,
  input  wire logic              wr_ce_i,
  input  wire logic              rd_clk_i,
  input  wire logic              rd_ce_i,
  input  wire cer_pkg::cer_wr_s  wr_i,
  input  wire cer_pkg::cer_rd_s  rd_i,
  output logic      [DATA_W-1:0] q_o,
  input  wire logic [3:0]        bus_addr_i,
  input  wire logic [31:0]       bus_wdata_i,
  input  wire logic              bus_we_i,
  input  wire logic              bus_re_i,
  output logic      [31:0]       bus_rdata_o
);

  // ***************************************************
  // configuration registers
  // ***************************************************
  cer_pkg::cer_cfg_s              cfg_reg;
  logic [AW-1:0]                  load_addr_reg;
  logic                           load_we;
  logic [cer_pkg::PHYS_WIDTH-1:0] load_data;

  assign load_we   = bus_we_i && (bus_addr_i == cer_pkg::OFS_LOAD_DATA);
  assign load_data = bus_wdata_i[cer_pkg::PHYS_WIDTH-1:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_reg <= cer_pkg::cer_cfg_s'(cer_pkg::CTRL_RESET);
    end else if (bus_we_i && bus_addr_i == cer_pkg::OFS_CTRL) begin
      cfg_reg <= cer_pkg::cer_cfg_s'(bus_wdata_i[cer_pkg::CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      load_addr_reg <= '0;
    end else if (bus_we_i && bus_addr_i == cer_pkg::OFS_LOAD_ADDR) begin
      load_addr_reg <= bus_wdata_i[AW-1:0];
    end else if (load_we) begin
      load_addr_reg <= load_addr_reg + AW'(1);
    end
  end

  // ***************************************************
  // clock pins: three-stage sampling and edge detect
  // ***************************************************
  logic [2:0] wck_sync_reg;
  logic [2:0] rck_sync_reg;
  logic       wck_lvl_reg;
  logic       rck_lvl_reg;
  logic       wck_rise;
  logic       rck_rise;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wck_sync_reg <= 3'h0;
      rck_sync_reg <= 3'h0;
    end else begin
      wck_sync_reg <= {wck_sync_reg[1:0], wr_clk_i};
      rck_sync_reg <= {rck_sync_reg[1:0], rd_clk_i};
    end
  end

  // a level counts only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wck_lvl_reg <= 1'b0;
      rck_lvl_reg <= 1'b0;
    end else begin
      if (wck_sync_reg[1] == wck_sync_reg[2]) wck_lvl_reg <= wck_sync_reg[2];
      if (rck_sync_reg[1] == rck_sync_reg[2]) rck_lvl_reg <= rck_sync_reg[2];
    end
  end

  assign wck_rise = (wck_sync_reg[1] == wck_sync_reg[2]) && wck_sync_reg[2] && !wck_lvl_reg;
  assign rck_rise = (rck_sync_reg[1] == rck_sync_reg[2]) && rck_sync_reg[2] && !rck_lvl_reg;

  // ***************************************************
  // section ticks
  // ***************************************************
  logic single_port;
  logic wr_tick;
  logic rd_tick;
  logic in_rd_tick;
  logic out_tick;

  assign single_port = (cfg_reg.mode == cer_pkg::CER_MODE_SP_RAM);

  assign wr_tick = wck_rise && wr_ce_i;
  // read clock, or write clock when single-port
  assign rd_tick = single_port ? wr_tick : (rck_rise && rd_ce_i);
  // with split_io or in single-port mode, input registers all on write clock; output on rd_tick, which is the write clock when single-port
  assign in_rd_tick = (cfg_reg.split_io || single_port) ? wr_tick : rd_tick;
  assign out_tick   = rd_tick;

  // ***************************************************
  // optional input registers
  // ***************************************************
  cer_pkg::cer_wr_s wr_reg;
  cer_pkg::cer_rd_s rd_reg;
  logic             commit_reg;

  always_ff @(posedge clk_i or posedge clear_i) begin
    if (clear_i) begin
      wr_reg     <= '0;
      commit_reg <= 1'b0;
    end else if (reset_i) begin
      wr_reg     <= '0;
      commit_reg <= 1'b0;
    end else begin
      // internal write strobe follows the write edge
      commit_reg <= wr_tick;
      if (wr_tick) wr_reg <= wr_i;
    end
  end

  always_ff @(posedge clk_i or posedge clear_i) begin
    if (clear_i) begin
      rd_reg <= '0;
    end else if (reset_i) begin
      rd_reg <= '0;
    end else if (in_rd_tick) begin
      rd_reg <= rd_i;
    end
  end

  // each path registered or straight through
  logic [AW-1:0]     waddr_eff;
  logic [DATA_W-1:0] wdata_eff;
  logic              we_eff;
  logic [AW-1:0]     raddr_eff;
  logic              re_eff;

  assign waddr_eff = cfg_reg.reg_waddr ? wr_reg.addr : wr_i.addr;
  assign wdata_eff = cfg_reg.reg_wdata ? wr_reg.data : wr_i.data;
  assign we_eff    = cfg_reg.reg_we    ? wr_reg.en   : wr_i.en;
  assign raddr_eff = single_port ? waddr_eff
                   : (cfg_reg.reg_raddr ? rd_reg.addr : rd_i.addr);
  assign re_eff    = cfg_reg.reg_re ? rd_reg.en : rd_i.en;

  // ***************************************************
  // fifo pointers
  // ***************************************************
  logic [AW-1:0]               fifo_wp_reg;
  logic [AW-1:0]               fifo_rp_reg;
  logic [cer_pkg::LEVEL_W-1:0] fifo_lvl_reg;
  logic [cer_pkg::LEVEL_W-1:0] depth;
  logic                        is_fifo;
  logic                        fifo_full;
  logic                        fifo_empty;
  logic                        user_wr;
  logic                        fifo_rd;

  assign depth      = cer_pkg::LEVEL_W'(cer_pkg::PHYS_DEPTH) << cfg_reg.ratio;
  assign is_fifo    = (cfg_reg.mode == cer_pkg::CER_MODE_FIFO);
  assign fifo_full  = (fifo_lvl_reg == depth);
  assign fifo_empty = (fifo_lvl_reg == '0);

  // write needs enable and enabled edge; rom refuses user writes
  assign user_wr = commit_reg && we_eff && (cfg_reg.mode != cer_pkg::CER_MODE_ROM)
                && !(is_fifo && fifo_full) && !load_we;
  assign fifo_rd = is_fifo && out_tick && re_eff && !fifo_empty;

  always_ff @(posedge clk_i or posedge clear_i) begin
    if (clear_i) begin
      fifo_wp_reg  <= '0;
      fifo_rp_reg  <= '0;
      fifo_lvl_reg <= '0;
    end else if (reset_i || !is_fifo) begin
      fifo_wp_reg  <= '0;
      fifo_rp_reg  <= '0;
      fifo_lvl_reg <= '0;
    end else begin
      if (user_wr) fifo_wp_reg <= (fifo_wp_reg + AW'(1)) & AW'(depth - 1'b1);
      if (fifo_rd) fifo_rp_reg <= (fifo_rp_reg + AW'(1)) & AW'(depth - 1'b1);
      if (user_wr && !fifo_rd) fifo_lvl_reg <= fifo_lvl_reg + 1'b1;
      else if (fifo_rd && !user_wr) fifo_lvl_reg <= fifo_lvl_reg - 1'b1;
    end
  end

  // ***************************************************
  // aspect ratio mapping onto the 256 x 16 array
  // ***************************************************
  logic [AW-1:0]                  mem_waddr;
  logic [AW-1:0]                  mem_raddr;
  logic [cer_pkg::PHYS_WIDTH-1:0] mem_wdata;
  logic [cer_pkg::PHYS_WIDTH-1:0] mem_wmask;
  logic [cer_pkg::PHYS_WIDTH-1:0] mem_rdata;
  logic [cer_pkg::PHYS_WIDTH-1:0] lane_mask;
  logic [4:0]                     lane_w;
  logic [4:0]                     wshift;
  logic [4:0]                     rshift;
  logic [2:0]                     lane_sel;
  logic [DATA_W-1:0]              rd_lane;
  logic [cer_pkg::PHYS_WIDTH-1:0] raw_wdata;
  logic                           mem_we;

  assign lane_w    = 5'(cer_pkg::PHYS_WIDTH) >> cfg_reg.ratio;
  assign lane_sel  = 3'((8'h1 << cfg_reg.ratio) - 8'h1);
  assign lane_mask = 16'((17'h1 << lane_w) - 17'h1);

  // configuration load wins over the user port
  assign mem_waddr = load_we ? load_addr_reg : (is_fifo ? fifo_wp_reg : waddr_eff);
  assign raw_wdata = load_we ? load_data : wdata_eff;
  assign mem_raddr = is_fifo ? fifo_rp_reg : raddr_eff;
  assign mem_we    = load_we || user_wr;

  // word and lane from the logical address
  assign wshift    = 5'(mem_waddr[2:0] & lane_sel) * lane_w;
  assign rshift    = 5'(mem_raddr[2:0] & lane_sel) * lane_w;
  assign mem_wmask = lane_mask << wshift;
  assign mem_wdata = (raw_wdata & lane_mask) << wshift;
  assign rd_lane   = (mem_rdata >> rshift) & lane_mask;

  cer_mem #(
    .WIDTH (cer_pkg::PHYS_WIDTH),
    .AW    (cer_pkg::PHYS_AW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (cer_pkg::PHYS_AW'(mem_waddr >> cfg_reg.ratio)),
    .wmask_i (mem_wmask),
    .wdata_i (mem_wdata),
    .raddr_i (cer_pkg::PHYS_AW'(mem_raddr >> cfg_reg.ratio)),
    .rdata_o (mem_rdata)
  );

  // ***************************************************
  // read output
  // ***************************************************
  // array data lag the address by one system clock; a read edge is far slower
  // registered output takes data on the read edge
  always_ff @(posedge clk_i or posedge clear_i) begin
    if (clear_i) begin
      q_o <= '0;
    end else if (reset_i) begin
      q_o <= '0;
    end else if (cfg_reg.reg_q) begin
      if (out_tick && re_eff) q_o <= rd_lane;
    end else if (re_eff) begin
      q_o <= rd_lane;
    end
  end

  // ***************************************************
  // register read port
  // ***************************************************
  // wider or deeper memories join blocks outside; status exposes fill
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_rdata_o <= 32'h0;
    end else begin
      bus_rdata_o <= 32'h0;
      if (bus_re_i) begin
        unique case (bus_addr_i)
          cer_pkg::OFS_CTRL:      bus_rdata_o <= 32'(cfg_reg);
          cer_pkg::OFS_LOAD_ADDR: bus_rdata_o <= 32'(load_addr_reg);
          cer_pkg::OFS_STATUS: begin
            bus_rdata_o[cer_pkg::STAT_EMPTY] <= fifo_empty;
            bus_rdata_o[cer_pkg::STAT_FULL]  <= fifo_full;
            bus_rdata_o[cer_pkg::STAT_LEVEL +: cer_pkg::LEVEL_W] <= fifo_lvl_reg;
          end
          default:                bus_rdata_o <= 32'h0;
        endcase
      end
    end
  end

endmodule

/* cer_block_asserts.sv */
// port checker for the configurable embedded ram block
// assumes it is bound into cer_block and sees only that module's ports
`timescale 1ns/1ps
module cer_block_asserts #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned AW     = 11
) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              clear_i,
  input wire logic              wr_clk_i,
  input wire logic              wr_ce_i,
  input wire logic              rd_clk_i,
  input wire logic              rd_ce_i,
  input wire cer_pkg::cer_wr_s  wr_i,
  input wire cer_pkg::cer_rd_s  rd_i,
  input wire logic [DATA_W-1:0] q_o,
  input wire logic [3:0]        bus_addr_i,
  input wire logic [31:0]       bus_wdata_i,
  input wire logic              bus_we_i,
  input wire logic              bus_re_i,
  input wire logic [31:0]       bus_rdata_o
);
  // shadow of the control word: tells the checks whether the output is registered
  cer_pkg::cer_cfg_s cfg_seen_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_seen_reg <= cer_pkg::cer_cfg_s'(cer_pkg::CTRL_RESET);
    end else if (bus_we_i && bus_addr_i == cer_pkg::OFS_CTRL) begin
      cfg_seen_reg <= cer_pkg::cer_cfg_s'(bus_wdata_i[cer_pkg::CTRL_W-1:0]);
    end
  end

  // ***************************************************
  // properties
  // ***************************************************
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_reset_out: assert property ($past(reset_i) |-> q_o == '0 && bus_rdata_o == '0)
    else $error("outputs not cleared after reset");
  a_clear_q: assert property (clear_i |-> q_o == '0)
    else $error("read data not cleared while clear is high");
  a_bus_idle: assert property (!$past(bus_re_i) |-> bus_rdata_o == 32'h0)
    else $error("register read data outside its cycle");
  a_unmapped_zero: assert property (
      $past(bus_re_i) && $past(bus_addr_i[1:0]) != 2'h0 |-> bus_rdata_o == 32'h0)
    else $error("unmapped register read not zero");
  a_ctrl_width: assert property (
      $past(bus_re_i) && $past(bus_addr_i) == cer_pkg::OFS_CTRL
      |-> bus_rdata_o[31:11] == 21'h0)
    else $error("control read has bits above its width");
  a_status_empty: assert property (
      $past(bus_re_i) && $past(bus_addr_i) == cer_pkg::OFS_STATUS
      |-> bus_rdata_o[0] == (bus_rdata_o[13:2] == 12'h0))
    else $error("empty flag disagrees with level");
  a_status_excl: assert property (
      $past(bus_re_i) && $past(bus_addr_i) == cer_pkg::OFS_STATUS
      |-> !(bus_rdata_o[0] && bus_rdata_o[1]))
    else $error("empty and full both set");
  // a registered output moves only on an edge of an enabled read section;
  // the registered enable may date from an earlier edge, so only the clock enable counts
  a_q_cause: assert property (
      $changed(q_o) && !clear_i && !$past(clear_i) && $past(cfg_seen_reg.reg_q)
      |-> $past((cfg_seen_reg.mode == cer_pkg::CER_MODE_SP_RAM) ? wr_ce_i : rd_ce_i))
    else $error("read data changed without an enabled read");
endmodule

bind cer_block cer_block_asserts #(.DATA_W(DATA_W), .AW(AW)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .clear_i(clear_i), .wr_clk_i(wr_clk_i),
  .wr_ce_i(wr_ce_i), .rd_clk_i(rd_clk_i), .rd_ce_i(rd_ce_i), .wr_i(wr_i), .rd_i(rd_i),
  .q_o(q_o), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_we_i(bus_we_i),
  .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o));

/* cer_fabric.sv */
// fabric user logic model driving the write and read sections
// assumes its tasks are called right after a rising clk_i edge
`timescale 1ns/1ps
module cer_fabric (
  input  wire logic        clk_i,
  output logic             wr_clk_o,
  output logic             wr_ce_o,
  output logic             rd_clk_o,
  output logic             rd_ce_o,
  output cer_pkg::cer_wr_s wr_o,
  output cer_pkg::cer_rd_s rd_o
);
  // one write and one read stream on a single block
  initial begin
    wr_clk_o = 1'b0;
    wr_ce_o  = 1'b0;
    rd_clk_o = 1'b0;
    rd_ce_o  = 1'b0;
    wr_o     = '0;
    rd_o     = '0;
  end

  // separate section clocks, slow against clk_i
  task automatic tick(input bit rd);
    repeat (2) @(posedge clk_i);
    if (rd) rd_clk_o <= 1'b1;
    else wr_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_clk_o <= 1'b0;
    wr_clk_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // address and data held around the write edge only
  task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic ce);
    wr_o    <= {a, d, 1'b1};
    wr_ce_o <= ce;
    tick(1'b0);
    wr_o    <= {~a, ~d, 1'b0};
    wr_ce_o <= 1'b0;
    // one idle edge so a following call never reassigns in the same step
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [10:0] a, input logic en, input logic ce);
    rd_o    <= {a, en};
    rd_ce_o <= ce;
    tick(1'b1);
    rd_o    <= {~a, 1'b0};
    rd_ce_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the configurable embedded ram block
// assumes cer_fabric drives the data ports and the bench drives the register bus
`timescale 1ns/1ps
module testbench;
  logic             clk_i;
  logic             reset_i;
  logic             clear;
  logic             wr_clk;
  logic             wr_ce;
  logic             rd_clk;
  logic             rd_ce;
  cer_pkg::cer_wr_s wr;
  cer_pkg::cer_rd_s rd;
  logic [15:0]      q;
  logic [3:0]       bus_addr;
  logic [31:0]      bus_wdata;
  logic [31:0]      bus_rdata;
  logic             bus_we;
  logic             bus_re;
  int               miscompares;
  int               samples_checked;
  int               cycles;

  cer_block dut (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clear), .wr_clk_i(wr_clk),
    .wr_ce_i(wr_ce), .rd_clk_i(rd_clk), .rd_ce_i(rd_ce), .wr_i(wr), .rd_i(rd), .q_o(q),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_we_i(bus_we), .bus_re_i(bus_re),
    .bus_rdata_o(bus_rdata));
  cer_fabric fab (.clk_i(clk_i), .wr_clk_o(wr_clk), .wr_ce_o(wr_ce), .rd_clk_o(rd_clk),
    .rd_ce_o(rd_ce), .wr_o(wr), .rd_o(rd));

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bwr(input logic [3:0] a, input logic [31:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_we    <= 1'b1;
    @(posedge clk_i);
    bus_we    <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic brd(input logic [3:0] a, output logic [31:0] d);
    bus_addr <= a;
    bus_re   <= 1'b1;
    @(posedge clk_i);
    bus_re   <= 1'b0;
    #1 d = bus_rdata;
    @(posedge clk_i);
  endtask

  // registered read: the first edge takes address and enable, the second gives data
  task automatic rchk(input logic [10:0] a, input logic [15:0] exp);
    fab.rd(a, 1'b1, 1'b1);
    fab.rd(a, 1'b0, 1'b1);
    chk("read data", {16'h0, exp}, {16'h0, q});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    logic [31:0] v;
    brd(cer_pkg::OFS_CTRL, v);
    chk("ctrl", 32'h0000_07E2, v);
    brd(4'h2, v);
    chk("unmapped", 32'h0, v);
    $display("test reset done");
  endtask

  // neighbouring addresses share a word in the narrow ratios, so lanes must not clash
  task automatic t_ratio;
    logic [15:0] m;
    for (int r = 0; r < 4; r++) begin
      m = 16'hFFFF >> (16 - (16 >> r));
      bwr(cer_pkg::OFS_CTRL, 32'h0000_07E2 | (32'(r) << 2));
      fab.wr(11'h00A, 16'hA5C3, 1'b1);
      fab.wr(11'h00B, 16'h5A3C, 1'b1);
      rchk(11'h00A, 16'hA5C3 & m);
      rchk(11'h00B, 16'h5A3C & m);
    end
    $display("test ratio done");
  endtask

  task automatic t_ce;
    bwr(cer_pkg::OFS_CTRL, 32'h0000_07E2);
    fab.wr(11'h003, 16'h1357, 1'b1);
    fab.wr(11'h003, 16'hFFFF, 1'b0);
    fab.wr(11'h004, 16'h2468, 1'b1);
    rchk(11'h003, 16'h1357);
    fab.rd(11'h004, 1'b1, 1'b0);
    fab.rd(11'h004, 1'b0, 1'b0);
    chk("held q", 32'h0000_1357, {16'h0, q});
    $display("test enable done");
  endtask

  task automatic t_rom;
    bwr(cer_pkg::OFS_CTRL, 32'h0000_07E1);
    bwr(cer_pkg::OFS_LOAD_ADDR, 32'h0000_0014);
    bwr(cer_pkg::OFS_LOAD_DATA, 32'h0000_1234);
    bwr(cer_pkg::OFS_LOAD_DATA, 32'h0000_5678);
    fab.wr(11'h014, 16'h9999, 1'b1);
    rchk(11'h014, 16'h1234);
    rchk(11'h015, 16'h5678);
    $display("test rom done");
  endtask

  task automatic t_clear;
    clear <= 1'b1;
    #1 chk("cleared q", 32'h0, {16'h0, q});
    @(posedge clk_i);
    clear <= 1'b0;
    @(posedge clk_i);
    $display("test clear done");
  endtask

  task automatic t_fifo;
    logic [31:0] v;
    bwr(cer_pkg::OFS_CTRL, 32'h0000_07E3);
    fab.wr(11'h000, 16'hBEEF, 1'b1);
    fab.wr(11'h000, 16'h0F0F, 1'b1);
    brd(cer_pkg::OFS_STATUS, v);
    chk("status two", 32'h0000_0008, v);
    rchk(11'h000, 16'hBEEF);
    rchk(11'h000, 16'h0F0F);
    brd(cer_pkg::OFS_STATUS, v);
    chk("status empty", 32'h0000_0001, v);
    $display("test fifo done");
  endtask

  // every path straight through: no section register between port and array
  task automatic t_comb;
    bwr(cer_pkg::OFS_CTRL, 32'h0000_0002);
    fab.wr(11'h021, 16'hC0DE, 1'b1);
    fab.rd(11'h021, 1'b1, 1'b1);
    chk("straight q", 32'h0000_C0DE, {16'h0, q});
    $display("test straight done");
  endtask

  // ***************************************************
  // clock, timeout and main sequence
  // ***************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // the whole run needs about 620 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    reset_i = 1'b1;
    clear = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 32'h0;
    bus_we = 1'b0;
    bus_re = 1'b0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_ratio();
    t_ce();
    t_rom();
    t_clear();
    t_fifo();
    t_comb();
    complete_run();
  end
endmodule
